/* hdl/hsbd_pkg.sv */
package hsbd_pkg;
  // descriptor field positions (lower 64 bits: DW1 upper, DW0 lower)
  localparam int TOKEN_HI = 43;
  localparam int TOKEN_LO = 42;
  localparam int FADDR_HI = 41;
  localparam int FADDR_LO = 35;
  localparam int EP_HI_HI = 34;
  localparam int EP_HI_LO = 32;
  localparam int EP_LSB = 31;
  localparam int MULT_HI = 30;
  localparam int MULT_LO = 29;
  localparam int MPS_HI = 28;
  localparam int MPS_LO = 18;
  localparam int BYTES_HI = 17;
  localparam int BYTES_LO = 3;
  localparam int ACTIVE_BIT = 0;
  // token codes in order of value
  localparam logic [1:0] TOK_OUT = 2'h0;
  localparam logic [1:0] TOK_IN = 2'h1;
  localparam logic [1:0] TOK_SETUP = 2'h2;
  localparam logic [1:0] TOK_PING = 2'h3;
  // register map (byte addresses)
  localparam logic [11:0] ADDR_DESC_LO = 12'h000;
  localparam logic [11:0] ADDR_DESC_HI = 12'h004;
  localparam logic [11:0] ADDR_NAK = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;
  localparam logic [11:0] ADDR_CTRL = 12'h010;
  // nak register layout: [3:0] counter, [7:4] reload
  localparam int NAK_CNT_LO = 0;
  localparam int NAK_RL_LO = 4;
  // ctrl register: write-one pulses
  localparam int CTRL_START = 0;
  localparam int CTRL_PING = 1;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage : hsbd_pkg

/* hdl/hsbd_field_split.sv */
`timescale 1ns/10ps
// combinational split of the lower descriptor half into its fields
module hsbd_field_split (
  // descriptor words
  input wire logic [31:0] desc_lo,
  input wire logic [31:0] desc_hi,
  // decoded fields
  output logic [1:0] token,
  output logic [6:0] function_addr,
  output logic [3:0] endpoint_number,
  output logic [1:0] mult,
  output logic [10:0] max_payload_size,
  output logic [14:0] transfer_byte_total,
  output logic active
);
  logic [63:0] d;
  assign d = {desc_hi, desc_lo};
  assign token = d[hsbd_pkg::TOKEN_HI:hsbd_pkg::TOKEN_LO];
  assign function_addr = d[hsbd_pkg::FADDR_HI:hsbd_pkg::FADDR_LO];
  assign endpoint_number = {d[hsbd_pkg::EP_HI_HI:hsbd_pkg::EP_HI_LO],
                            d[hsbd_pkg::EP_LSB]};
  assign mult = d[hsbd_pkg::MULT_HI:hsbd_pkg::MULT_LO];
  assign max_payload_size = d[hsbd_pkg::MPS_HI:hsbd_pkg::MPS_LO];
  assign transfer_byte_total = d[hsbd_pkg::BYTES_HI:hsbd_pkg::BYTES_LO];
  // bits 2:1 are not looked at
  assign active = d[hsbd_pkg::ACTIVE_BIT];
endmodule : hsbd_field_split

/* hdl/hsbd_top.sv */
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
module hsbd_top (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // transaction engine
  input wire logic pkt_done,
  input wire logic [10:0] pkt_bytes,
  input wire logic pkt_ack,
  input wire logic pkt_nak,
  input wire logic fatal_err,
  // packet request to the engine
  output logic pkt_req,
  output logic [1:0] pkt_token,
  output logic [6:0] pkt_function_addr,
  output logic [3:0] pkt_endpoint_number,
  output logic [10:0] pkt_len,
  output logic desc_active
);
  typedef enum logic [1:0] {IDLE, ISSUE, WAIT} hsbd_state_t;
  typedef struct packed {
    hsbd_state_t st;
    logic [31:0] desc_lo;
    logic [31:0] desc_hi;
    logic [3:0] nak_cnt;
    logic [3:0] nak_rl;
    logic [1:0] pkts_left;
    logic [14:0] remaining;
    logic fatal_seen;
    logic resume;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pkt_req;
    logic [1:0] pkt_token;
    logic [6:0] pkt_function_addr;
    logic [3:0] pkt_endpoint_number;
    logic [10:0] pkt_len;
    logic desc_active;
  } hsbd_regs_t;

  hsbd_regs_t r, next_r;

  logic [1:0] f_token;
  logic [6:0] f_faddr;
  logic [3:0] f_ep;
  logic [1:0] f_mult;
  logic [10:0] f_mps;
  logic [14:0] f_total;
  logic f_active;

  hsbd_field_split u_split (
    .desc_lo(r.desc_lo),
    .desc_hi(r.desc_hi),
    .token(f_token),
    .function_addr(f_faddr),
    .endpoint_number(f_ep),
    .mult(f_mult),
    .max_payload_size(f_mps),
    .transfer_byte_total(f_total),
    .active(f_active)
  );

  logic setup_ph, access_ph, wr, rd;
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable && r.pready;
  assign wr = access_ph && pwrite;
  assign rd = access_ph && !pwrite;

  always_comb begin
    logic [10:0] chunk;
    logic done_all;
    chunk = 11'h000;
    done_all = 1'b0;
    next_r = r;
    next_r.pkt_req = 1'b0;
    // no wait state: pready rises in the first access cycle
    next_r.pready = setup_ph;
    next_r.pslverr = 1'b0;
    if (setup_ph && !pwrite) begin
      unique case (paddr)
        hsbd_pkg::ADDR_DESC_LO: next_r.prdata = r.desc_lo;
        hsbd_pkg::ADDR_DESC_HI: next_r.prdata = r.desc_hi;
        hsbd_pkg::ADDR_NAK: next_r.prdata = {24'h000000, r.nak_rl, r.nak_cnt};
        hsbd_pkg::ADDR_STATUS: next_r.prdata = {13'h0000, r.st == IDLE ? 1'b0 : 1'b1,
                                                r.fatal_seen, r.remaining, r.pkts_left};
        default: next_r.prdata = hsbd_pkg::ZERO32;
      endcase
    end
    if (setup_ph) begin
      unique case (paddr)
        hsbd_pkg::ADDR_DESC_LO, hsbd_pkg::ADDR_DESC_HI, hsbd_pkg::ADDR_NAK,
        hsbd_pkg::ADDR_STATUS, hsbd_pkg::ADDR_CTRL: next_r.pslverr = 1'b0;
        default: next_r.pslverr = 1'b1;
      endcase
    end
    if (wr && !r.pslverr) begin
      unique case (paddr)
        hsbd_pkg::ADDR_DESC_LO: begin
          next_r.desc_lo = pwdata;
          // a fresh descriptor starts from its full byte total
          next_r.resume = 1'b0;
        end
        hsbd_pkg::ADDR_DESC_HI: begin
          next_r.desc_hi = pwdata;
          // software may not place the ping code
          if (pwdata[hsbd_pkg::TOKEN_HI-32 -: 2] == hsbd_pkg::TOK_PING) begin
            next_r.desc_hi[hsbd_pkg::TOKEN_HI-32 -: 2] = r.desc_hi[hsbd_pkg::TOKEN_HI-32 -: 2];
          end
        end
        hsbd_pkg::ADDR_NAK: begin
          next_r.nak_cnt = pwdata[hsbd_pkg::NAK_CNT_LO +: 4];
          next_r.nak_rl = pwdata[hsbd_pkg::NAK_RL_LO +: 4];
        end
        hsbd_pkg::ADDR_CTRL: begin
          if (pwdata[hsbd_pkg::CTRL_PING]) begin
            next_r.desc_hi[hsbd_pkg::TOKEN_HI-32 -: 2] = hsbd_pkg::TOK_PING;
          end
          if (pwdata[hsbd_pkg::CTRL_START] && f_active && r.st == IDLE) begin
            next_r.st = ISSUE;
            next_r.pkts_left = f_mult;
            // a restart after the multiplier ran out carries on from the bytes left,
            // otherwise the same bytes would be moved again and the descriptor never ends
            if (!r.resume) begin
              next_r.remaining = f_total;
            end
            next_r.resume = 1'b0;
            next_r.fatal_seen = 1'b0;
          end
        end
        default: ;
      endcase
    end
    unique case (r.st)
      IDLE: ;
      ISSUE: begin
        chunk = (r.remaining > {4'h0, f_mps}) ? f_mps : r.remaining[10:0];
        next_r.pkt_req = 1'b1;
        next_r.pkt_token = f_token;
        next_r.pkt_function_addr = f_faddr;
        next_r.pkt_endpoint_number = f_ep;
        next_r.pkt_len = chunk;
        next_r.st = WAIT;
      end
      WAIT: begin
        if (fatal_err) begin
          next_r.fatal_seen = 1'b1;
          done_all = 1'b1;
        end else if (pkt_done && pkt_ack) begin
          next_r.nak_cnt = r.nak_rl;
          next_r.remaining = r.remaining - {4'h0, pkt_bytes};
          if (r.remaining <= {4'h0, pkt_bytes} || pkt_bytes < r.pkt_len) begin
            done_all = 1'b1;
          end else if (r.pkts_left <= 2'h1) begin
            next_r.st = IDLE;
            next_r.resume = 1'b1;
          end else begin
            next_r.pkts_left = r.pkts_left - 2'h1;
            next_r.st = ISSUE;
          end
        end else if (pkt_done && pkt_nak) begin
          if (r.nak_rl != 4'h0 && r.nak_cnt <= 4'h1) begin
            next_r.nak_cnt = 4'h0;
            done_all = 1'b1;
          end else begin
            if (r.nak_rl != 4'h0) begin
              next_r.nak_cnt = r.nak_cnt - 4'h1;
            end
            next_r.st = ISSUE;
          end
        end
        if (done_all) begin
          next_r.desc_lo[hsbd_pkg::ACTIVE_BIT] = 1'b0;
          next_r.st = IDLE;
        end
      end
    endcase
    next_r.desc_active = next_r.desc_lo[hsbd_pkg::ACTIVE_BIT];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign pkt_req = r.pkt_req;
  assign pkt_token = r.pkt_token;
  assign pkt_function_addr = r.pkt_function_addr;
  assign pkt_endpoint_number = r.pkt_endpoint_number;
  assign pkt_len = r.pkt_len;
  assign desc_active = r.desc_active;

  sequence s_fatal_wait;
    r.st == WAIT && fatal_err;
  endsequence

  a_fatal_clears_active: assert property (@(posedge pclk) disable iff (!presetn)
    s_fatal_wait |=> !desc_active && r.st == IDLE) else $error("active not cleared on fatal");
  a_len_within_mps: assert property (@(posedge pclk) disable iff (!presetn)
    pkt_req |-> pkt_len <= f_mps) else $error("packet longer than max payload");
  a_req_fields_match: assert property (@(posedge pclk) disable iff (!presetn)
    pkt_req |-> pkt_function_addr == r.desc_hi[9:3] && pkt_endpoint_number == f_ep)
    else $error("address fields mismatch");
  a_ep_assembly: assert property (@(posedge pclk) disable iff (!presetn)
    f_ep == {r.desc_hi[2:0], r.desc_lo[31]}) else $error("endpoint assembly wrong");
  a_total_field: assert property (@(posedge pclk) disable iff (!presetn)
    f_total == r.desc_lo[17:3]) else $error("byte total field wrong");
  a_ack_reloads_nak: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == WAIT && pkt_done && pkt_ack && !fatal_err |=> r.nak_cnt == $past(r.nak_rl))
    else $error("nak counter not reloaded");
  a_nak_zero_stops: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == WAIT && pkt_done && pkt_nak && !pkt_ack && r.nak_rl != 4'h0 && r.nak_cnt == 4'h1
    |=> !desc_active) else $error("active kept after nak exhaustion");
  a_no_sw_ping: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == hsbd_pkg::ADDR_DESC_HI && pwdata[11:10] == hsbd_pkg::TOK_PING
    && r.desc_hi[11:10] != hsbd_pkg::TOK_PING |=> r.desc_hi[11:10] != hsbd_pkg::TOK_PING)
    else $error("software placed ping");
  a_mult_bound: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == ISSUE |-> r.pkts_left <= f_mult) else $error("more packets than multiplier");

  // bus timing: no wait state, the answer stands a single cycle
  a_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");

  // steps of a packet exchange with the engine
  sequence s_ack_wait;
    r.st == WAIT && !fatal_err && pkt_done && pkt_ack;
  endsequence

  sequence s_nak_wait;
    r.st == WAIT && !fatal_err && pkt_done && pkt_nak && !pkt_ack;
  endsequence

  sequence s_start_write;
    wr && !r.pslverr && paddr == hsbd_pkg::ADDR_CTRL && pwdata[hsbd_pkg::CTRL_START];
  endsequence

  // packet sequencing
  a_start_issues: assert property (@(posedge pclk) disable iff (!presetn)
    s_start_write ##0 (desc_active && r.st == IDLE) |=> r.st == ISSUE ##1 pkt_req)
    else $error("start did not issue a packet");
  a_req_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    pkt_req |=> !pkt_req)
    else $error("packet request longer than one cycle");
  a_token_carried: assert property (@(posedge pclk) disable iff (!presetn)
    pkt_req |-> pkt_token == $past(r.desc_hi[11:10]))
    else $error("token not carried to the packet");
  a_ping_by_ctrl: assert property (@(posedge pclk) disable iff (!presetn)
    wr && !r.pslverr && paddr == hsbd_pkg::ADDR_CTRL && pwdata[hsbd_pkg::CTRL_PING]
    |=> r.desc_hi[11:10] == hsbd_pkg::TOK_PING)
    else $error("hardware ping not placed");
  a_next_packet: assert property (@(posedge pclk) disable iff (!presetn)
    s_ack_wait ##0 (r.remaining > {4'h0, pkt_bytes} && pkt_bytes >= pkt_len
    && r.pkts_left > 2'h1) |=> r.st == ISSUE ##1 pkt_req)
    else $error("next packet not issued");
  a_mult_used_up: assert property (@(posedge pclk) disable iff (!presetn)
    s_ack_wait ##0 (r.remaining > {4'h0, pkt_bytes} && pkt_bytes >= pkt_len
    && r.pkts_left <= 2'h1) |=> r.st == IDLE && desc_active)
    else $error("multiplier not honoured");

  // byte accounting and completion
  a_bytes_counted: assert property (@(posedge pclk) disable iff (!presetn)
    s_ack_wait |=> r.remaining == $past(r.remaining) - {4'h0, $past(pkt_bytes)})
    else $error("remaining bytes not reduced");
  a_done_clears: assert property (@(posedge pclk) disable iff (!presetn)
    s_ack_wait ##0 (r.remaining <= {4'h0, pkt_bytes}) |=> !desc_active && r.st == IDLE)
    else $error("active kept after last packet");
  a_idle_keeps_active: assert property (@(posedge pclk) disable iff (!presetn)
    r.st == IDLE && !(wr && paddr == hsbd_pkg::ADDR_DESC_LO) |=> $stable(desc_active))
    else $error("active changed while idle");

  // nak handling
  a_nak_counts_down: assert property (@(posedge pclk) disable iff (!presetn)
    s_nak_wait ##0 (r.nak_rl != 4'h0 && r.nak_cnt > 4'h1)
    |=> r.nak_cnt == $past(r.nak_cnt) - 4'h1 && desc_active)
    else $error("nak counter not decremented");
endmodule : hsbd_top

/* verif/hsbd_engine_model.sv */
`timescale 1ns/10ps
// stands in for the transaction engine and the function behind it
module hsbd_engine_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request and test controls: kind 0 ack, 1 nak, 2 fatal, 3 short ack
  input wire logic pkt_req,
  input wire logic [10:0] pkt_len,
  input wire logic [1:0] kind,
  input wire logic [3:0] delay,
  // answer to the block
  output logic pkt_done,
  output logic [10:0] pkt_bytes,
  output logic pkt_ack,
  output logic pkt_nak,
  output logic fatal_err
);
  logic [10:0] len_q;
  logic [1:0] kind_q;
  int wait_n;
  initial {pkt_done, pkt_ack, pkt_nak, fatal_err, pkt_bytes} = '0;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {pkt_done, pkt_ack, pkt_nak, fatal_err} <= 4'h0;
      wait_n <= -1;
    end else begin
      {pkt_done, pkt_ack, pkt_nak, fatal_err} <= 4'h0;
      // byte count is not held once the pulse is over
      pkt_bytes <= ~pkt_bytes;
      if (pkt_req) begin
        // latched here so the bench may queue the next answer early
        len_q <= pkt_len;
        kind_q <= kind;
        wait_n <= int'(delay);
      end else if (wait_n > 0) begin
        wait_n <= wait_n - 1;
      end else if (wait_n == 0) begin
        wait_n <= -1;
        fatal_err <= (kind_q == 2'h2);
        pkt_done <= (kind_q != 2'h2);
        pkt_ack <= kind_q[0] == kind_q[1];
        pkt_nak <= (kind_q == 2'h1);
        pkt_bytes <= (kind_q == 2'h3) ? len_q - 11'h001 : len_q;
      end
    end
  end
endmodule : hsbd_engine_model

/* verif/testbench.sv */
`timescale 1ns/10ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic pkt_done, pkt_ack, pkt_nak, fatal_err, pkt_req, desc_active;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [10:0] pkt_bytes, pkt_len;
  logic [1:0] pkt_token, kind;
  logic [6:0] pkt_function_addr;
  logic [3:0] pkt_endpoint_number, delay;
  int mismatches, cmp_count, cycles;

  hsbd_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pkt_done(pkt_done), .pkt_bytes(pkt_bytes), .pkt_ack(pkt_ack),
    .pkt_nak(pkt_nak), .fatal_err(fatal_err), .pkt_req(pkt_req), .pkt_token(pkt_token),
    .pkt_function_addr(pkt_function_addr), .pkt_endpoint_number(pkt_endpoint_number),
    .pkt_len(pkt_len), .desc_active(desc_active));
  hsbd_engine_model i_eng (.pclk(pclk), .presetn(presetn), .pkt_req(pkt_req),
    .pkt_len(pkt_len), .kind(kind), .delay(delay), .pkt_done(pkt_done),
    .pkt_bytes(pkt_bytes), .pkt_ack(pkt_ack), .pkt_nak(pkt_nak), .fatal_err(fatal_err));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      $display("mismatch at %0t: run hung", $time);
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed: only the bench timeout ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  task automatic step(input logic [1:0] k, tk, input logic [6:0] fa,
      input logic [3:0] ep, input logic [10:0] len);
    int n;
    n = 0;
    kind <= k;
    delay <= 4'($urandom_range(0, 6));
    do begin
      @(posedge pclk);
      n++;
    end while (pkt_req !== 1'b1 && n < 100);
    chk(pkt_token, tk, "token");
    chk(pkt_function_addr, fa, "address");
    chk(pkt_endpoint_number, ep, "endpoint");
    chk(pkt_len, len, "length");
  endtask : step

  task automatic run_desc(input logic [1:0] tok, input int npk, fail_at,
      input logic [1:0] fk);
    logic [6:0] fa;
    logic [3:0] ep;
    logic [1:0] mult, k;
    logic [10:0] mps;
    int rem, pk, cnt, i;
    fa = 7'($urandom);
    ep = 4'($urandom);
    mult = 2'($urandom_range(1, 3));
    // no park mode on this side, so the plain multiplier is loaded
    mps = 11'($urandom_range(1, 512));
    rem = npk * int'(mps);
    cnt = 1;
    apb(1'b1, hsbd_pkg::ADDR_NAK, 32'h0000_0021);
    apb(1'b1, hsbd_pkg::ADDR_DESC_HI, {20'h0_0000, tok == 2'h3 ? 2'h1 : tok, fa, ep[3:1]});
    // reserved bits left zero, active set
    apb(1'b1, hsbd_pkg::ADDR_DESC_LO, {ep[0], mult, mps, 15'(rem), 3'h1});
    if (tok == 2'h3) apb(1'b1, hsbd_pkg::ADDR_CTRL, 32'h0000_0002);
    apb(1'b1, hsbd_pkg::ADDR_CTRL, 32'h0000_0001);
    pk = int'(mult);
    for (i = 0; i < 40; i++) begin
      k = (i >= fail_at) ? fk : 2'h0;
      step(k, tok, fa, ep, mps);
      if (k == 2'h0) begin
        rem = rem - int'(mps);
        pk = pk - 1;
        // an acknowledged packet reloads the nak counter from its reload value
        cnt = 2;
      end
      if (k == 2'h1) cnt--;
      if (k >= 2'h2 || rem == 0 || cnt == 0) break;
      if (pk == 0) begin
        // multiplier used up: descriptor stays active until restarted
        repeat (16) @(posedge pclk);
        chk(desc_active, 1'b1, "held active");
        apb(1'b0, hsbd_pkg::ADDR_STATUS, 32'h0);
        chk(q[16:2], rem, "bytes left");
        apb(1'b1, hsbd_pkg::ADDR_CTRL, 32'h0000_0001);
        pk = int'(mult);
      end
    end
    for (i = 0; i < 40 && desc_active !== 1'b0; i++) @(posedge pclk);
    chk(desc_active, 1'b0, "active cleared");
    apb(1'b0, hsbd_pkg::ADDR_DESC_LO, 32'h0);
    chk(q[0], 1'b0, "active bit");
    apb(1'b0, hsbd_pkg::ADDR_STATUS, 32'h0);
    if (fk == 2'h2) chk(q[17], 1'b1, "fatal seen");
  endtask : run_desc

  initial begin
    {psel, penable, pwrite, kind, delay, paddr, pwdata, presetn} = '0;
    {mismatches, cmp_count, cycles} = '0;
    void'($urandom(33));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 16; a += 4) begin
      apb(1'b0, 12'(a), 32'h0);
      chk(q, 32'h0, "reset value");
    end
    apb(1'b0, 12'h014, 32'h0);
    chk(err, 1'b1, "unmapped");
    apb(1'b1, 12'h018, 32'hFFFF_FFFF);
    chk(err, 1'b1, "unmapped write");
    apb(1'b1, hsbd_pkg::ADDR_DESC_HI, 32'h0000_0400);
    apb(1'b1, hsbd_pkg::ADDR_DESC_HI, 32'h0000_0C00);
    apb(1'b0, hsbd_pkg::ADDR_DESC_HI, 32'h0);
    chk(q[11:10], 2'h1, "software ping");
    for (int t = 0; t < 4; t++) run_desc(2'(t), $urandom_range(1, 4), 99, 2'h0);
    run_desc(2'h1, 3, 1, 2'h3);
    run_desc(2'h0, 3, 1, 2'h2);
    run_desc(2'h1, 3, 1, 2'h1);
    end_sim();
  end
endmodule : testbench
